// ==== hw/dcwd_decode.sv ====
`timescale 1ns/1ps
`include "dcwd_regs.svh"
module dcwd_decode
   import dcwd_pkg::*;
(
   input  wire logic [31:0]      i_cfg1,
   input  wire logic [31:0]      i_cfg2,
   output logic      [4:0]       o_ps_exp,
   output dcwd_eighths_type      o_win_eighths,
   output dcwd_div_type          o_pll_div,
   output logic                  o_posc_off
);
   // ======================================================================
   // Field extraction
   wire logic [1:0] win_sz = i_cfg1[`DCWD_WINSZ_LSB +: 2];
   wire logic [4:0] ps_raw = i_cfg1[`DCWD_WDT_POSTSCALE_SELECT_LSB +: 5];
   wire logic [2:0] idiv   = i_cfg2[`DCWD_PLLIDIV_LSB +: 3];
   // Out-of-range codes saturate to the top ratio
   assign o_ps_exp = (ps_raw > `DCWD_PS_MAX) ? `DCWD_PS_MAX : ps_raw; // [R4] [R5]
   // 25, 37.5, 50, 75 percent as eighths
   assign o_win_eighths = (win_sz == 2'h3) ? 3'h2 :
                          (win_sz == 2'h2) ? 3'h3 :
                          (win_sz == 2'h1) ? 3'h4 : 3'h6; // [R1]
   assign o_pll_div = (idiv == 3'h7) ? 5'h0c :
                      (idiv == 3'h6) ? 5'h0a :
                      (idiv == 3'h5) ? 5'h06 :
                      (idiv == 3'h4) ? 5'h05 :
                      5'({2'h0, idiv} + 5'h01); // [R6]
   // Flags a config that stops the primary oscillator
   assign o_posc_off = (i_cfg1[`DCWD_PRIMARY_OSC_MODE_LSB +: 2] == `DCWD_POSC_OFF);
endmodule : dcwd_decode

// ==== hw/dcwd_top.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "dcwd_regs.svh"
// How it works
// R1: Window size code 11/10/01/00 gives 25/37.5/50/75 percent.
// R2: Fuse enable forces watchdog on; otherwise software may enable it.
// R3: Window-disable bit 1 means non-window mode, 0 window mode.
// R4: Postscale code n selects ratio two to the power n.
// R5: Postscale codes above 10100 act as 10100.
// R6: PLL divider codes 111/110/101/100 divide by 12/10/6/5.
// R7: Programmer must not set oscillator mode 11 with primary source.
// R8: USB PLL enable bit exists only on some variants.
// R9: Upper two write-protect bits exist only on 256 KB parts.
// R10: Part ID holds 4-bit revision on top, 28-bit identifier below.
// R11: Config control resets to 000b; four lock/enable bits.
// R12: Programmer writes ones to reserved word-1 bits 31:26 and 21.
// R13: Config words load at reset and read back read-only.
module dcwd_top
   import dcwd_pkg::*;
#(
   parameter bit          HAS_USB_PLL  = 1'b1,
   parameter bit          HAS_256K     = 1'b1,
   // Arbitrary neutral identity values
   parameter logic [3:0]  REVISION     = 4'h1,
   parameter logic [27:0] PART_ID      = 28'h0000001,
   parameter int          ADDR_W       = 16
)(
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_n,
   input  wire logic [31:0]       i_nv_cfg0,
   input  wire logic [31:0]       i_nv_cfg1,
   input  wire logic [31:0]       i_nv_cfg2,
   input  wire logic [31:0]       i_nv_cfg3,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   input  wire logic [3:0]        i_pstrb,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   output logic                   o_wdt_enable,
   output logic                   o_wdt_window_mode,
   output logic      [4:0]        o_wdt_postscale_exp,
   output logic      [2:0]        o_wdt_window_eighths,
   output logic      [4:0]        o_pll_input_divider,
   output logic                   o_usb_pll_enable,
   output logic      [8:0]        o_program_write_protect,
   output logic                   o_posc_disabled,
   output logic                   o_pin_select_lock,
   output logic                   o_peripheral_disable_lock,
   output logic                   o_jtag_port_enable,
   output logic                   o_test_data_out_enable
);
   // Decoder compares the low 16 address bits; any address bits above 15 must be zero
   generate
      if (ADDR_W < 16) begin : g_bad_addr_w
         $error("dcwd_top: ADDR_W must be at least 16");
      end
   endgenerate

   // ======================================================================
   // Configuration image, captured while reset is held
   logic [31:0] cfg_q [4];
   logic [31:0] cfg_d [4];
   wire logic [31:0] nv_in [4];
   assign nv_in[0] = i_nv_cfg0;
   assign nv_in[1] = i_nv_cfg1;
   assign nv_in[2] = i_nv_cfg2;
   assign nv_in[3] = i_nv_cfg3;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cfg
         // Sample is clocked, never an async load of a port
         assign cfg_d[gi] = (!i_rst_n) ? nv_in[gi] : cfg_q[gi]; // [R13]
         always_ff @(posedge i_clk_sys) begin
            cfg_q[gi] <= cfg_d[gi];
         end
      end
   endgenerate

   // Variant masking of unimplemented fields
   wire logic [31:0] cfg2_vis = HAS_USB_PLL ? cfg_q[2] :
                     (cfg_q[2] & ~(32'h1 << `DCWD_USB_PLL_ENABLE_BIT)); // [R8]
   wire logic [31:0] cfg0_vis = HAS_256K ? cfg_q[0] :
                     (cfg_q[0] & ~(32'h3 << (`DCWD_PWP_LSB + 7))); // [R9]
   // Reserved bits of word 1 read as programmed; ones are expected
   wire logic [31:0] cfg1_vis = cfg_q[1]; // [R12]

   // ======================================================================
   // Decoding
   logic [4:0]       ps_exp;
   dcwd_eighths_type win_e;
   dcwd_div_type     pdiv;
   logic             posc_off;
   dcwd_decode u_decode (
      .i_cfg1        (cfg1_vis),
      .i_cfg2        (cfg2_vis),
      .o_ps_exp      (ps_exp),
      .o_win_eighths (win_e),
      .o_pll_div     (pdiv),
      .o_posc_off    (posc_off)
   );

   // ======================================================================
   // APB slave: one wait state, pready rises in second access cycle
   dcwd_state_type st_q, st_d;
   wire logic setup  = i_psel && !i_penable;
   wire logic access = i_psel && i_penable && (st_q == DCWD_ST_ACC);
   wire logic [15:0] a16 = i_paddr[15:0];
   wire logic hit_c3 = (a16 == `DCWD_OFS_CFG3);
   wire logic hit_c2 = (a16 == `DCWD_OFS_CFG2);
   wire logic hit_c1 = (a16 == `DCWD_OFS_CFG1);
   wire logic hit_c0 = (a16 == `DCWD_OFS_CFG0);
   wire logic hit_cc = (a16 == `DCWD_OFS_CONFIG_CONTROL);
   wire logic hit_id = (a16 == `DCWD_OFS_PARTID);
   wire logic hit_ky = (a16 == `DCWD_OFS_KEY);
   wire logic hit_wc = (a16 == `DCWD_OFS_WDTCTL);
   wire logic upper_ok = (ADDR_W == 16) ? 1'b1 :
                         (i_paddr >> 16) == '0;
   wire logic hit_any = upper_ok && (hit_c3 || hit_c2 || hit_c1 ||
                        hit_c0 || hit_cc || hit_id || hit_ky || hit_wc);
   // Config words and part ID are read-only: writes error
   wire logic ro_hit = hit_c3 || hit_c2 || hit_c1 || hit_c0 || hit_id;
   wire logic bad    = !hit_any || (i_pwrite && ro_hit); // [R13]
   // Write lands only on the edge that samples pready high
   wire logic wr_ok  = o_pready && i_psel && i_penable && i_pwrite && !bad;
   wire logic [31:0] bmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                              {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

   always_comb begin
      st_d = st_q;
      case (st_q)
         DCWD_ST_IDLE: begin
            if (setup) begin
               st_d = DCWD_ST_ACC;
            end
         end
         DCWD_ST_ACC: begin
            st_d = DCWD_ST_IDLE;
         end
         default: begin
            st_d = DCWD_ST_IDLE;
         end
      endcase
   end

   // ======================================================================
   // Writable registers
   logic [31:0] config_control_q, config_control_d;
   logic [31:0] key_q, key_d;
   logic        sw_wdt_on_q, sw_wdt_on_d;
   assign config_control_d = (wr_ok && hit_cc) ?
      (((config_control_q & ~bmask) | (i_pwdata & bmask)) & `DCWD_CONFIG_CONTROL_MASK)
      : config_control_q; // [R11]
   assign key_d = (wr_ok && hit_ky) ?
      ((key_q & ~bmask) | (i_pwdata & bmask)) : key_q;
   assign sw_wdt_on_d = (wr_ok && hit_wc && i_pstrb[0]) ?
                        i_pwdata[0] : sw_wdt_on_q;

   // Fuse enable overrides any software clear
   wire logic fuse_on = cfg1_vis[`DCWD_WDT_FUSE_ENABLE_BIT];
   wire logic wdt_en  = fuse_on || sw_wdt_on_q; // [R2]
   wire logic win_md  = !cfg1_vis[`DCWD_WDT_WINDOW_DISABLE_BIT]; // [R3]

   wire logic [31:0] id_word = {REVISION, PART_ID}; // [R10]
   wire logic [31:0] rd_mux =
      hit_c3 ? cfg_q[3] :
      hit_c2 ? cfg2_vis :
      hit_c1 ? cfg1_vis :
      hit_c0 ? cfg0_vis :
      hit_cc ? config_control_q :
      hit_id ? id_word :
      hit_ky ? key_q :
      hit_wc ? {31'h0, wdt_en} : 32'h0;
   wire logic [31:0] prdata_d = (access && !i_pwrite && !bad) ?
                                rd_mux : 32'h0;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st_q        <= DCWD_ST_IDLE;
         config_control_q    <= `DCWD_CONFIG_CONTROL_RST; // [R11]
         key_q       <= `DCWD_KEY_RST;
         sw_wdt_on_q <= 1'b0; // [R2]
      end else begin
         st_q        <= st_d;
         config_control_q    <= config_control_d;
         key_q       <= key_d;
         sw_wdt_on_q <= sw_wdt_on_d;
      end
   end

   // ======================================================================
   // Registered outputs; pready/prdata are valid in the second access cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_pready                  <= 1'b0;
         o_prdata                  <= 32'h0;
         o_pslverr                 <= 1'b0;
         o_wdt_enable              <= 1'b0;
         o_wdt_window_mode         <= 1'b0;
         o_wdt_postscale_exp       <= 5'h0;
         o_wdt_window_eighths      <= 3'h0;
         o_pll_input_divider       <= 5'h0;
         o_usb_pll_enable          <= 1'b0;
         o_program_write_protect   <= 9'h0;
         o_posc_disabled           <= 1'b0;
         o_pin_select_lock         <= 1'b0;
         o_peripheral_disable_lock <= 1'b0;
         o_jtag_port_enable        <= 1'b0;
         o_test_data_out_enable    <= 1'b0;
      end else begin
         o_pready                  <= access;
         o_prdata                  <= prdata_d;
         o_pslverr                 <= access && bad;
         o_wdt_enable              <= wdt_en; // [R2]
         o_wdt_window_mode         <= win_md; // [R3]
         o_wdt_postscale_exp       <= ps_exp; // [R4] [R5]
         o_wdt_window_eighths      <= win_e; // [R1]
         o_pll_input_divider       <= pdiv; // [R6]
         o_usb_pll_enable          <= cfg2_vis[`DCWD_USB_PLL_ENABLE_BIT]; // [R8]
         o_program_write_protect   <= cfg0_vis[`DCWD_PWP_LSB +: 9]; // [R9]
         o_posc_disabled           <= posc_off; // [R7]
         o_pin_select_lock         <= config_control_q[`DCWD_PIN_SELECT_LOCK_BIT];
         o_peripheral_disable_lock <= config_control_q[`DCWD_PERIPHERAL_DISABLE_LOCK_BIT];
         o_jtag_port_enable        <= config_control_q[`DCWD_JTAG_PORT_ENABLE_BIT];
         o_test_data_out_enable    <= config_control_q[`DCWD_TEST_DATA_OUT_ENABLE_BIT];
      end
   end
endmodule : dcwd_top

// ==== inc/dcwd_pkg.sv ====
package dcwd_pkg;
   // Window fraction in eighths of the period
   typedef logic [2:0] dcwd_eighths_type;
   typedef logic [4:0] dcwd_div_type;
   typedef enum logic [1:0] {
      DCWD_ST_IDLE = 2'b00,
      DCWD_ST_ACC  = 2'b01
   } dcwd_state_type;
endpackage : dcwd_pkg

// ==== inc/dcwd_regs.svh ====
`ifndef DCWD_REGS_SVH
`define DCWD_REGS_SVH
// ==========================================================================
// Register byte addresses
`define DCWD_OFS_CFG3      16'h0bf0
`define DCWD_OFS_CFG2      16'h0bf4
`define DCWD_OFS_CFG1      16'h0bf8
`define DCWD_OFS_CFG0      16'h0bfc
`define DCWD_OFS_CONFIG_CONTROL    16'hf200
`define DCWD_OFS_PARTID    16'hf220
`define DCWD_OFS_KEY       16'hf230
`define DCWD_OFS_WDTCTL    16'hf240
// ==========================================================================
// Field positions in config word 1
`define DCWD_WINSZ_LSB     24
`define DCWD_WDT_FUSE_ENABLE_BIT    23
`define DCWD_WDT_WINDOW_DISABLE_BIT    22
`define DCWD_WDT_POSTSCALE_SELECT_LSB     16
`define DCWD_PRIMARY_OSC_MODE_LSB   8
// Config word 2 and 0
`define DCWD_USB_PLL_ENABLE_BIT    15
`define DCWD_PLLIDIV_LSB   0
`define DCWD_PWP_LSB       10
// Control register bits
`define DCWD_PIN_SELECT_LOCK_BIT    13
`define DCWD_PERIPHERAL_DISABLE_LOCK_BIT   12
`define DCWD_JTAG_PORT_ENABLE_BIT    3
`define DCWD_TEST_DATA_OUT_ENABLE_BIT     0
`define DCWD_CONFIG_CONTROL_MASK   32'h0000300b
// ==========================================================================
// Reset values, reserved masks and decode constants
`define DCWD_CONFIG_CONTROL_RST    32'h0000000b
`define DCWD_KEY_RST       32'h00000000
`define DCWD_CFG1_RSV      32'hfc200000
`define DCWD_PS_MAX        5'h14
`define DCWD_POSC_OFF      2'h3
`endif

// ==== verif/dcwd_checker.sv ====
`timescale 1ns/1ps
module dcwd_checker #(
   parameter bit HAS_256K = 1'b1
)(
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic [31:0] i_nv_cfg0,
   input wire logic [31:0] i_nv_cfg1,
   input wire logic [31:0] i_nv_cfg2,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [15:0] i_paddr,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_wdt_enable,
   input wire logic [4:0]  o_wdt_postscale_exp,
   input wire logic [2:0]  o_wdt_window_eighths,
   input wire logic [4:0]  o_pll_input_divider,
   input wire logic [8:0]  o_program_write_protect,
   input wire logic        o_jtag_port_enable,
   input wire logic        o_test_data_out_enable
);
   // ==========================================================
   // Shadow of the words captured while reset is low
   logic [31:0] c0_q;
   logic [31:0] c1_q;
   logic [31:0] c2_q;
   logic [4:0]  ps;
   logic [1:0]  ws;
   assign ps = c1_q[20:16];
   assign ws = c1_q[25:24];
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         c0_q <= i_nv_cfg0;
         c1_q <= i_nv_cfg1;
         c2_q <= i_nv_cfg2;
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // Checks
   win_size_a: assert property ($past(i_rst_n) |->
      o_wdt_window_eighths == (ws == 2'h3 ? 3'h2 : ws == 2'h2 ? 3'h3 :
      ws == 2'h1 ? 3'h4 : 3'h6)) else $error("window size wrong");
   fuse_on_a: assert property ($past(i_rst_n) && c1_q[23]
      |-> o_wdt_enable) else $error("fused watchdog off");
   ps_pass_a: assert property ($past(i_rst_n) && ps <= 5'h14
      |-> o_wdt_postscale_exp == ps) else $error("postscale wrong");
   ps_sat_a: assert property ($past(i_rst_n) && ps > 5'h14
      |-> o_wdt_postscale_exp == 5'h14) else $error("no saturation");
   pll_div_a: assert property ($past(i_rst_n) && c2_q[2] |->
      o_pll_input_divider == (c2_q[1] ? (c2_q[0] ? 5'hc : 5'ha) :
      (c2_q[0] ? 5'h6 : 5'h5))) else $error("divider wrong");
   wp_upper_a: assert property ($past(i_rst_n) |->
      o_program_write_protect[8:7] == (HAS_256K ? c0_q[18:17] : 2'h0))
      else $error("write protect upper bits wrong");
   ctl_reset_a: assert property ($rose(i_rst_n) |=>
      o_jtag_port_enable && o_test_data_out_enable)
      else $error("control reset wrong");
   ro_write_a: assert property (o_pready && i_pwrite &&
      i_paddr[15:12] == 4'h0 |-> o_pslverr) else $error("RO written");
   one_wait_a: assert property (i_psel && !i_penable ##1 i_psel &&
      i_penable |-> !o_pready ##1 o_pready) else $error("wait wrong");
   cover property (o_pready && o_pslverr);
   cover property (o_pready && i_pwrite && !o_pslverr);
   cover property ($past(i_rst_n) && ps > 5'h14);
endmodule : dcwd_checker

bind dcwd_top dcwd_checker #(.HAS_256K(HAS_256K)) dcwd_checker_i (.*);

// ==== verif/dcwd_tb_top.sv ====
`timescale 1ns/1ps
module dcwd_tb_top;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic [31:0] i_nv_cfg0 = 32'h0007fc00, i_nv_cfg1 = 32'hfcff0300;
   logic [31:0] i_nv_cfg2 = 32'h00008007, i_nv_cfg3 = 32'h1234abcd;
   logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [15:0] i_paddr  = 16'h0;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [3:0]  i_pstrb  = 4'hf;
   logic        o_pready, o_pslverr, o_wdt_enable, o_wdt_window_mode, er;
   logic        o_usb_pll_enable, o_posc_disabled, o_pin_select_lock;
   logic        o_peripheral_disable_lock, o_jtag_port_enable;
   logic        o_test_data_out_enable;
   logic [4:0]  o_wdt_postscale_exp, o_pll_input_divider;
   logic [2:0]  o_wdt_window_eighths;
   logic [8:0]  o_program_write_protect;
   int          mismatches = 0, n_tests = 0, cyc = 0;
   always #10 i_clk_sys = ~i_clk_sys;
   // Identity values are arbitrary
   dcwd_top #(.HAS_USB_PLL(1'b0), .HAS_256K(1'b0), .REVISION(4'h5),
      .PART_ID(28'h0a5c3e1)) dcwd_top_i (.*);
   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [31:0] d, e, input logic ee);
      @(posedge i_clk_sys);
      i_psel    <= 1'b1;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      // Flop outputs read at the edge show the value sampled there
      do begin
         @(posedge i_clk_sys);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
      if (!w) chk(rd, e);
      chk(er, ee);
   endtask : xfer
   // Outputs lag reset release by one clock, so settle three cycles
   task automatic boot(input logic [31:0] c0, c1, c2);
      @(posedge i_clk_sys);
      i_nv_cfg0 <= c0;
      i_nv_cfg1 <= c1;
      i_nv_cfg2 <= c2;
      i_rst_n   <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      repeat (3) @(negedge i_clk_sys);
   endtask : boot
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      xfer(1'b0, 16'hf200, 32'h0, 32'h0000000b, 1'b0);
      xfer(1'b0, 16'hf230, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, 16'hf220, 32'h0, 32'h50a5c3e1, 1'b0);
      xfer(1'b0, 16'h0bf0, 32'h0, 32'h1234abcd, 1'b0);
      xfer(1'b1, 16'h0bf8, 32'h0, 32'h0, 1'b1);
      xfer(1'b0, 16'h0bf8, 32'h0, 32'hfcff0300, 1'b0);
      xfer(1'b1, 16'hf220, 32'h0, 32'h0, 1'b1);
      xfer(1'b0, 16'h1000, 32'h0, 32'h0, 1'b1);
      xfer(1'b1, 16'hf200, 32'hffffffff, 32'h0, 1'b0);
      xfer(1'b0, 16'hf200, 32'h0, 32'h0000300b, 1'b0);
      repeat (2) @(negedge i_clk_sys);
      chk({o_pin_select_lock, o_peripheral_disable_lock,
           o_jtag_port_enable, o_test_data_out_enable}, 32'hf);
      xfer(1'b1, 16'hf230, 32'ha5a55a5a, 32'h0, 1'b0);
      xfer(1'b0, 16'hf230, 32'h0, 32'ha5a55a5a, 1'b0);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_decode;
      logic [4:0] ps [5] = '{5'h00, 5'h0b, 5'h14, 5'h15, 5'h1f};
      logic [2:0] ew [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
      logic [4:0] dv [4] = '{5'h5, 5'h6, 5'ha, 5'hc};
      logic [1:0] c;
      for (int i = 0; i < 5; i++) begin
         c = i[1:0];
         // Clock source field stays 0, so oscillator mode 11 is legal
         boot({13'h0, 2'h3, 7'(i), 10'h0},
              {6'h3f, c, i[0], i[1], 1'b1, ps[i], 6'h0, c, 8'h0},
              {16'h0, i[0], 12'h0, 1'b1, c});
         chk(o_wdt_window_eighths, ew[c]);
         chk(o_wdt_enable, i[0]);
         chk(o_wdt_window_mode, !i[1]);
         chk(o_wdt_postscale_exp, ps[i] > 5'h14 ? 5'h14 : ps[i]);
         chk(o_pll_input_divider, dv[c]);
         chk(o_usb_pll_enable, 1'b0);
         chk(o_program_write_protect, 7'(i));
         chk(o_posc_disabled, c == 2'h3);
      end
      $display("t_decode done");
   endtask : t_decode
   task automatic t_wdt;
      boot(32'h0, 32'hfc200000, 32'h0);
      chk(o_wdt_enable, 1'b0);
      xfer(1'b1, 16'hf240, 32'h1, 32'h0, 1'b0);
      repeat (2) @(negedge i_clk_sys);
      chk(o_wdt_enable, 1'b1);
      boot(32'h0, 32'hfca00000, 32'h0);
      xfer(1'b1, 16'hf240, 32'h0, 32'h0, 1'b0);
      repeat (2) @(negedge i_clk_sys);
      chk(o_wdt_enable, 1'b1);
      $display("t_wdt done");
   endtask : t_wdt
   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      t_regs();
      t_decode();
      t_wdt();
      wrap_up();
   end
endmodule : dcwd_tb_top
